//--- core/srsc_pkg.sv
`default_nettype none
package srsc_pkg;
    // clock and reset timing, times in ns, TCL counts in half clock periods
    localparam int CLK_PERIOD_NS = 4;
    localparam int HALF_PERIOD_NS = CLK_PERIOD_NS / 2;
    localparam int FILTER_NS = 500;
    localparam int SHORT_TCL = 4;
    localparam int LONG_TCL = 1032 + 12;
    localparam int SEQ_TCL = 1032;

    // least times round up to whole cycles, never below one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc

    localparam int SHORT_MIN_NS = (SHORT_TCL * HALF_PERIOD_NS > FILTER_NS) ?
        SHORT_TCL * HALF_PERIOD_NS : FILTER_NS;
    localparam logic [9:0] FILT_CYC = 10'(ns_to_cyc(SHORT_MIN_NS));
    localparam logic [9:0] LONG_CYC =
        10'(ns_to_cyc(LONG_TCL * HALF_PERIOD_NS + SHORT_MIN_NS));
    localparam logic [9:0] SEQ_CYC = 10'(ns_to_cyc(SEQ_TCL * HALF_PERIOD_NS));

    // register map, byte addresses
    localparam logic [3:0] OFS_SYSCFG = 4'h0;
    localparam logic [3:0] OFS_SOURCE = 4'h4;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
    localparam logic [3:0] OFS_IRQ_MASK = 4'hc;

    // system configuration fields
    localparam logic [15:0] SYSCFG_RST = 16'h0000;
    localparam int SYSCFG_BIDIR_BIT = 3;
    localparam int SYSCFG_STRAP0_BIT = 7;
    localparam int SYSCFG_STRAP1_BIT = 9;
    localparam int SYSCFG_STRAP2_BIT = 10;

    // reset source flags, also the interrupt status layout
    typedef struct packed {
        logic software;
        logic watchdog;
        logic long_hw;
        logic short_hw;
        logic async_hw;
        logic power_on;
    } srsc_src_t;

    localparam srsc_src_t SRC_NONE = 6'h00;
    localparam srsc_src_t SRC_POWER_ON = 6'h01;

    typedef enum logic [1:0] {
        SRSC_IDLE = 2'b00,
        SRSC_PIN_LOW = 2'b01,
        SRSC_SEQ = 2'b10
    } srsc_state_t;

    typedef enum logic [1:0] {
        KIND_HW = 2'b00,
        KIND_WDT = 2'b01,
        KIND_SW = 2'b10
    } srsc_kind_t;
endpackage : srsc_pkg
`default_nettype wire

//--- core/srsc_top.sv
// Functional notes
// - six reset sources, each with defined state
// - record reset source in its flag
// - sense high, very long pulse: sync long
// - sense high, medium pulse: sync short, flag
// - sense low during sync reset: go async
// - once async, finish as async
// - software/watchdog sequences ignore sense level
// - pin low enables sense pull-down
// - bidir drive only if enabled, sense high
// - filtered reset qualifies the sense level
// - config register reloads pattern with straps
// - reload value is the same for every reset kind
`default_nettype none
module srsc_top (
    input wire logic clk,
    input wire logic rst,
    // reset pin, low active, open drain
    input wire logic reset_input_pin_i,
    output logic reset_pin_o,
    output logic reset_pin_oe,
    input wire logic reset_mode_sense,
    output logic sense_pulldown_en,
    input wire logic watchdog_overflow,
    input wire logic software_reset_instruction,
    input wire logic [2:0] config_strap,
    output logic core_reset,
    output logic filtered_reset_n,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq
);
    srsc_pkg::srsc_state_t state_q;
    srsc_pkg::srsc_kind_t kind_q;
    srsc_pkg::srsc_src_t flags_q;
    srsc_pkg::srsc_src_t status_q;
    srsc_pkg::srsc_src_t mask_q;
    srsc_pkg::srsc_src_t done_src;
    logic [2:0] pin_sync_q;
    logic [2:0] sense_sync_q;
    logic pin_lvl_q;
    logic sense_lvl_q;
    logic [9:0] cnt_q;
    logic async_q;
    logic long_q;
    logic drive_q;
    logic seq_done;
    logic hw_start;
    logic hw_release;
    logic filt_active;
    logic cfg_load_q;
    logic [15:0] syscfg_q;
    logic [31:0] readdata_q;
    logic wait_q;
    logic irq_q;
    logic core_reset_q;
    logic filt_n_q;
    logic pulldown_q;
    logic bus_req;
    logic wr_ok;

    // pin inputs: three stages, level accepted when stages two and three agree
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pin_sync_q <= 3'h7;
            sense_sync_q <= 3'h7;
            pin_lvl_q <= 1'b1;
            sense_lvl_q <= 1'b1;
        end
        else
        begin
            pin_sync_q <= {pin_sync_q[1:0], reset_input_pin_i};
            sense_sync_q <= {sense_sync_q[1:0], reset_mode_sense};
            if (pin_sync_q[1] == pin_sync_q[2])
            begin
                pin_lvl_q <= pin_sync_q[2];
            end
            if (sense_sync_q[1] == sense_sync_q[2])
            begin
                sense_lvl_q <= sense_sync_q[2];
            end
        end
    end

    // our own drive pulls the pin low too, so the pin is ignored while driving
    assign hw_start = (state_q == srsc_pkg::SRSC_IDLE) && !pin_lvl_q;
    assign hw_release = (state_q == srsc_pkg::SRSC_PIN_LOW) && pin_lvl_q;
    // the sense level counts only once the noise filter has passed the pulse
    assign filt_active = (state_q == srsc_pkg::SRSC_PIN_LOW) &&
        (cnt_q >= srsc_pkg::FILT_CYC);
    assign seq_done = (state_q == srsc_pkg::SRSC_SEQ) &&
        (cnt_q == srsc_pkg::SEQ_CYC - 10'h001);

    // source state machine: pin pulse measurement, then internal sequence
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= srsc_pkg::SRSC_IDLE;
            kind_q <= srsc_pkg::KIND_HW;
            cnt_q <= 10'h000;
        end
        else
        begin
            unique case (state_q)
                srsc_pkg::SRSC_IDLE:
                begin
                    cnt_q <= 10'h000;
                    if (hw_start)
                    begin
                        state_q <= srsc_pkg::SRSC_PIN_LOW;
                        kind_q <= srsc_pkg::KIND_HW;
                    end
                    else if (watchdog_overflow)
                    begin
                        state_q <= srsc_pkg::SRSC_SEQ;
                        kind_q <= srsc_pkg::KIND_WDT;
                    end
                    else if (software_reset_instruction)
                    begin
                        state_q <= srsc_pkg::SRSC_SEQ;
                        kind_q <= srsc_pkg::KIND_SW;
                    end
                end
                srsc_pkg::SRSC_PIN_LOW:
                begin
                    if (cnt_q != 10'h3ff)
                    begin
                        cnt_q <= cnt_q + 10'h001;
                    end
                    if (hw_release)
                    begin
                        cnt_q <= 10'h000;
                        // pulses the filter swallows leave no trace
                        state_q <= filt_active ? srsc_pkg::SRSC_SEQ
                                               : srsc_pkg::SRSC_IDLE;
                    end
                end
                srsc_pkg::SRSC_SEQ:
                begin
                    cnt_q <= cnt_q + 10'h001;
                    if (seq_done)
                    begin
                        state_q <= srsc_pkg::SRSC_IDLE;
                        cnt_q <= 10'h000;
                    end
                end
                default:
                begin
                    state_q <= srsc_pkg::SRSC_IDLE;
                    cnt_q <= 10'h000;
                end
            endcase
        end
    end

    // sync to async conversion, sticky until the sequence ends
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            async_q <= 1'b0;
        end
        else if (state_q == srsc_pkg::SRSC_IDLE)
        begin
            async_q <= 1'b0;
        end
        else if (!sense_lvl_q && kind_q == srsc_pkg::KIND_HW &&
                 (filt_active || state_q == srsc_pkg::SRSC_SEQ))
        begin
            async_q <= 1'b1;
        end
        // a later high sense level does not undo it
        // watchdog and software sequences never convert
    end

    // pulse length class, taken at the pin release
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            long_q <= 1'b0;
        end
        else if (hw_release)
        begin
            long_q <= (cnt_q >= srsc_pkg::LONG_CYC);
        end
    end

    // bidirectional drive for watchdog and software resets
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            drive_q <= 1'b0;
        end
        else if (state_q == srsc_pkg::SRSC_IDLE && !hw_start &&
                 (watchdog_overflow || software_reset_instruction))
        begin
            drive_q <= syscfg_q[srsc_pkg::SYSCFG_BIDIR_BIT] && sense_lvl_q;
        end
        else if (seq_done || !sense_lvl_q)
        begin
            drive_q <= 1'b0;
        end
    end

    // source of the finished sequence, one hot
    always_comb
    begin
        done_src = srsc_pkg::SRC_NONE;
        unique case (kind_q)
            srsc_pkg::KIND_WDT: done_src.watchdog = 1'b1;
            srsc_pkg::KIND_SW: done_src.software = 1'b1;
            srsc_pkg::KIND_HW:
            begin
                done_src.async_hw = async_q;
                done_src.long_hw = !async_q && long_q;
                done_src.short_hw = !async_q && !long_q;
            end
            default: done_src = srsc_pkg::SRC_NONE;
        endcase
    end

    // source flags replaced only by the next completed reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            flags_q <= srsc_pkg::SRC_POWER_ON;
        end
        else if (seq_done)
        begin
            flags_q <= done_src;
        end
    end

    // config reload: straps are caught by the clock after each reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cfg_load_q <= 1'b1;
            syscfg_q <= srsc_pkg::SYSCFG_RST;
        end
        else
        begin
            cfg_load_q <= seq_done;
            if (cfg_load_q)
            begin
                // every reset clears the bidir enable; software must set it
                // again before a later software or watchdog reset drives the pin
                syscfg_q <= srsc_pkg::SYSCFG_RST;
                syscfg_q[srsc_pkg::SYSCFG_STRAP0_BIT] <= config_strap[0];
                syscfg_q[srsc_pkg::SYSCFG_STRAP1_BIT] <= config_strap[1];
                syscfg_q[srsc_pkg::SYSCFG_STRAP2_BIT] <= config_strap[2];
            end
            else if (wr_ok && avs_address == srsc_pkg::OFS_SYSCFG)
            begin
                syscfg_q <= avs_writedata[15:0];
            end
        end
    end

    // pin side outputs and core reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            core_reset_q <= 1'b1;
            filt_n_q <= 1'b1;
            pulldown_q <= 1'b0;
        end
        else
        begin
            core_reset_q <= filt_active || (state_q == srsc_pkg::SRSC_SEQ && !seq_done);
            filt_n_q <= !filt_active;
            pulldown_q <= !pin_lvl_q || drive_q;
        end
    end

    // bus: one wait cycle, write lands on the edge where waitrequest is low
    assign bus_req = avs_read || avs_write;
    assign wr_ok = avs_write && !wait_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wait_q <= 1'b1;
            readdata_q <= 32'h0000_0000;
        end
        else if (bus_req && wait_q)
        begin
            wait_q <= 1'b0;
            unique case (avs_address)
                srsc_pkg::OFS_SYSCFG: readdata_q <= {16'h0000, syscfg_q};
                srsc_pkg::OFS_SOURCE: readdata_q <= {26'h0, flags_q};
                srsc_pkg::OFS_IRQ_STATUS: readdata_q <= {26'h0, status_q};
                srsc_pkg::OFS_IRQ_MASK: readdata_q <= {26'h0, mask_q};
                default: readdata_q <= 32'h0000_0000;
            endcase
        end
        else
        begin
            wait_q <= 1'b1;
        end
    end

    // interrupt status: set wins over a same-cycle write of one
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            status_q <= srsc_pkg::SRC_POWER_ON;
            mask_q <= srsc_pkg::SRC_NONE;
        end
        else
        begin
            if (wr_ok && avs_address == srsc_pkg::OFS_IRQ_STATUS)
            begin
                status_q <= (status_q & ~avs_writedata[5:0]) | (seq_done ? done_src : 6'h00);
            end
            else if (seq_done)
            begin
                status_q <= status_q | done_src;
            end
            if (wr_ok && avs_address == srsc_pkg::OFS_IRQ_MASK)
            begin
                mask_q <= avs_writedata[5:0];
            end
        end
    end

    // level interrupt, one cycle behind the status bits
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(status_q & mask_q);
        end
    end

    assign reset_pin_o = 1'b0;
    assign reset_pin_oe = drive_q;
    assign sense_pulldown_en = pulldown_q;
    assign core_reset = core_reset_q;
    assign filtered_reset_n = filt_n_q;
    assign avs_readdata = readdata_q;
    assign avs_waitrequest = wait_q;
    assign irq = irq_q;
endmodule : srsc_top
`default_nettype wire

//--- dv/srsc_sva.sv
`default_nettype none
module srsc_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_input_pin_i,
    input wire logic reset_pin_o,
    input wire logic reset_pin_oe,
    input wire logic reset_mode_sense,
    input wire logic sense_pulldown_en,
    input wire logic software_reset_instruction,
    input wire logic core_reset,
    input wire logic filtered_reset_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] run_q;
    logic pin_q;

    // latest low run of the raw pin, held while high, since the filter
    // may fire a few cycles after the pin is already back up
    always_ff @(posedge clk)
    begin
        pin_q <= reset_input_pin_i;
        if (rst)
            run_q <= 12'h000;
        else if (!reset_input_pin_i)
            run_q <= pin_q ? 12'h001 : run_q + {11'h000, run_q != 12'hfff};
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_pin_data: assert property (reset_pin_o == 1'b0)
        else $error("pin data not low");
    a_rst_state: assert property ($fell(rst) |-> avs_waitrequest && !irq
        && !reset_pin_oe && filtered_reset_n) else $error("bad state after reset");
    a_filter_min: assert property ($fell(filtered_reset_n) |-> run_q >= 12'h07d)
        else $error("short pulse passed filter");
    a_filt_core: assert property (!filtered_reset_n |-> core_reset)
        else $error("filtered reset without core reset");
    a_seq_hold: assert property ($rose(filtered_reset_n) |-> core_reset [*8])
        else $error("sequence cut short");
    a_oe_sense: assert property (!reset_mode_sense [*6] |-> !reset_pin_oe)
        else $error("pin driven with sense low");
    a_oe_pull: assert property (reset_pin_oe [*2] |-> sense_pulldown_en)
        else $error("no pull-down while driving");
    a_oe_core: assert property (reset_pin_oe && $past(reset_pin_oe) |-> core_reset)
        else $error("pin driven outside reset");
    a_sw_start: assert property (software_reset_instruction && !core_reset
        && reset_input_pin_i && $past(reset_input_pin_i, 5) |-> ##[1:3] core_reset)
        else $error("software reset not started");
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("no bus answer");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
endmodule : srsc_sva

bind srsc_top srsc_sva u_srsc_sva (.clk(clk), .rst(rst),
    .reset_input_pin_i(reset_input_pin_i), .reset_pin_o(reset_pin_o),
    .reset_pin_oe(reset_pin_oe), .reset_mode_sense(reset_mode_sense),
    .sense_pulldown_en(sense_pulldown_en),
    .software_reset_instruction(software_reset_instruction),
    .core_reset(core_reset), .filtered_reset_n(filtered_reset_n),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
`default_nettype wire

//--- dv/srsc_board.sv
`default_nettype none
module srsc_board (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [11:0] len,
    input wire logic cap_hi,
    input wire logic oe,
    output logic pin,
    output logic sense
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] cnt_q;

    // board switch holds the pin low for the whole requested length
    always_ff @(posedge clk)
    begin
        if (rst)
            cnt_q <= 12'h000;
        else if (start)
            cnt_q <= len;
        else if (cnt_q != 12'h000)
            cnt_q <= cnt_q - 12'h001;
    end

    // open drain with pull-up: low if either side drives
    assign pin = !(cnt_q != 12'h000 || oe);
    // capacitor level on the sense pin, chosen by the bench
    assign sense = cap_hi;
endmodule : srsc_board
`default_nettype wire

//--- dv/srsc_top_test.sv
`default_nettype none
module srsc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic [11:0] len = 12'h000;
    logic cap_hi = 1'b1;
    logic wdt = 1'b0;
    logic software_reset_flag = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    wire logic pin, sense, oe, pd, core, filt_n, wait_r, irq;
    logic [31:0] rdata, q;
    int err_total = 0;
    int tests_run = 0;

    // 4 ns period
    always #2 clk = ~clk;

    srsc_top u_srsc_top (.clk(clk), .rst(rst), .reset_input_pin_i(pin),
        .reset_pin_o(), .reset_pin_oe(oe), .reset_mode_sense(sense),
        .sense_pulldown_en(pd), .watchdog_overflow(wdt),
        .software_reset_instruction(software_reset_flag), .config_strap(3'h5),
        .core_reset(core), .filtered_reset_n(filt_n), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_readdata(rdata), .avs_waitrequest(wait_r), .irq(irq));
    srsc_board u_srsc_board (.clk(clk), .rst(rst), .start(start), .len(len),
        .cap_hi(cap_hi), .oe(oe), .pin(pin), .sense(sense));

    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // request held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do
        begin
            @(posedge clk);
            n++;
        end while (wait_r !== 1'b0 && n < 50);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50)
        begin
            err_total++;
            summarize();
        end
    endtask : bus

    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rchk

    task automatic wait_core(input logic lvl);
        int n;
        n = 0;
        while (core !== lvl && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000)
        begin
            err_total++;
            summarize();
        end
    endtask : wait_core

    task automatic pull(input logic [11:0] n);
        @(posedge clk);
        start <= 1'b1;
        len <= n;
        @(posedge clk);
        start <= 1'b0;
    endtask : pull

    // one-cycle pulse on a request line: 0 software, 1 watchdog
    task automatic pulse(input logic dog);
        @(posedge clk);
        software_reset_flag <= !dog;
        wdt <= dog;
        @(posedge clk);
        software_reset_flag <= 1'b0;
        wdt <= 1'b0;
        wait_core(1'b1);
        repeat (8) @(posedge clk);
    endtask : pulse

    // pin reset; optional sense dip while the filtered reset is low
    task automatic hw(input logic [11:0] n, input logic dip, input logic [31:0] e);
        pull(n);
        if (dip)
        begin
            repeat (150) @(posedge clk);
            cap_hi <= 1'b0;
            repeat (20) @(posedge clk);
            cap_hi <= 1'b1;
        end
        wait_core(1'b1);
        chk({31'h0, pd}, 32'h1);
        wait_core(1'b0);
        rchk(4'h4, e);
    endtask : hw

    task automatic t_por;
        rchk(4'h4, 32'h01);
        rchk(4'h0, 32'h480);
        bus(1'b1, 4'h4, 32'h3f);
        rchk(4'h4, 32'h01);
        rchk(4'h2, 32'h0);
        $display("test por done");
    endtask : t_por

    task automatic t_glitch;
        pull(12'h064);
        repeat (140) @(posedge clk);
        chk({31'h0, filt_n}, 32'h1);
        chk({31'h0, core}, 32'h0);
        $display("test glitch done");
    endtask : t_glitch

    task automatic t_pin;
        hw(12'h0c8, 1'b0, 32'h04);
        hw(12'h2bc, 1'b0, 32'h08);
        $display("test pin done");
    endtask : t_pin

    task automatic t_sw;
        bus(1'b1, 4'h0, 32'h488);
        pulse(1'b0);
        chk({29'h0, oe, pd, pin}, 32'h6);
        wait_core(1'b0);
        rchk(4'h4, 32'h20);
        rchk(4'h0, 32'h480);
        $display("test software done");
    endtask : t_sw

    task automatic t_wdt;
        // every reset clears the bidir enable, so set it again
        bus(1'b1, 4'h0, 32'h488);
        cap_hi <= 1'b0;
        repeat (8) @(posedge clk);
        pulse(1'b1);
        chk({31'h0, oe}, 32'h0);
        cap_hi <= 1'b1;
        wait_core(1'b0);
        rchk(4'h4, 32'h10);
        $display("test watchdog done");
    endtask : t_wdt

    task automatic t_async;
        hw(12'h0c8, 1'b1, 32'h02);
        rchk(4'h0, 32'h480);
        $display("test async done");
    endtask : t_async

    task automatic t_irq;
        bus(1'b1, 4'hc, 32'h02);
        rchk(4'hc, 32'h02);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 4'h8, 32'h02);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b0, 4'h8, 32'h0);
        chk(q & 32'h02, 32'h0);
        $display("test irq done");
    endtask : t_irq

    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_por();
        t_glitch();
        t_pin();
        t_sw();
        t_wdt();
        t_async();
        t_irq();
        summarize();
    end
endmodule : srsc_top_test
`default_nettype wire
